// ==== design/acsr_defines.svh ====
// Offsets, field positions and reset values of the auxiliary control register block
`ifndef ACSR_DEFINES_SVH
`define ACSR_DEFINES_SVH

// ==========================================================================
// Register byte addresses
`define ACSR_ADDR_AUX       8'h48
`define ACSR_ADDR_IRQ_STAT  8'h4c
`define ACSR_ADDR_IRQ_MASK  8'h50

// ==========================================================================
// Auxiliary control field positions
`define ACSR_BIT_AUTOINC    0
`define ACSR_BIT_RSVD       1
`define ACSR_BIT_SYNCTO     2
`define ACSR_BIT_TWOIDX     3
`define ACSR_BIT_CLRDMA     4
`define ACSR_BIT_HPRST      5
`define ACSR_BIT_DETEN      6
`define ACSR_BIT_BYTERDY    7

// ==========================================================================
// Interrupt status field positions
`define ACSR_EV_SYNCTO      0
`define ACSR_EV_TWOIDX      1
`define ACSR_EV_HPRST       2
`define ACSR_EV_BYTERDY     3

// ==========================================================================
// Reset values
`define ACSR_AUX_RESET      8'h00
`define ACSR_EV_RESET       4'h0
`define ACSR_RDATA_RESET    32'h0000_0000

`endif

// ==== design/acsr_pkg.sv ====
// Types shared by the auxiliary control register block
package acsr_pkg;

  // ========================================================================
  // Control store word fields seen by the detector
  typedef struct packed {
    logic step;       // One-cycle pulse: a new word executes
    logic readGate;   // Read gate field bit
    logic dataXfer;   // Data transfer field bit
    logic countBit5;  // Count field bit 5
  } acsr_wcs_t;

  // ========================================================================
  // Software-written control bits
  typedef struct packed {
    logic detEn;      // Two-index detection enable
    logic clrDma;     // Clear host DMA enable strobe
    logic autoInc;    // Buffer pointer auto-increment
  } acsr_ctrl_t;

  // ========================================================================
  // Two-index detector states, Gray along idle, armed, detected
  typedef enum logic [1:0] {
    DET_IDLE     = 2'b00,
    DET_ARMED    = 2'b01,
    DET_DETECTED = 2'b11
  } acsr_det_t;

endpackage

// ==== design/acsr_top.sv ====
// Auxiliary control and status register with two-index detector and Avalon-MM slave
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ns
`include "acsr_defines.svh"

module acsr_top #(
  parameter int ADDR_W = 8  // Avalon byte address width
) (
  input  wire logic              clock,
  input  wire logic              resetn,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // Pins and neighbouring logic
  input  wire logic              host_reset_pin,
  input  wire logic              hostProgReset,
  input  wire logic              formatterReset,
  input  wire logic              syncTimeoutPulse,
  input  wire logic              byteReady,
  input  wire logic              indexPulse,
  input  wire logic              fmtBufXfer,
  input  wire logic              bufPortAccess,
  input  wire acsr_pkg::acsr_wcs_t wcsWord,
  // Results
  output logic                   bufPtrIncr,
  output logic                   clearDmaEnable,
  output logic                   detArmed,
  output logic                   fmtStopped,
  output logic                   irq
);
  import acsr_pkg::*;

  // ==========================================================================
  // Reset release and pin synchronisers
  logic [1:0] rstPipe_r;   // Reset release pipe
  logic       rstn;        // Synchronised reset
  logic [1:0] hrstPipe_r;  // Host reset pin pipe
  logic [1:0] idxPipe_r;   // Index pin pipe
  logic       idxLast_r;   // Previous synchronised index
  logic       hostRst;     // Synchronised host reset pin
  logic       idxEdge;     // Rising index edge

  // Reset release through two flops
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rstPipe_r <= 2'h0;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
  end
  assign rstn = rstPipe_r[1];

  // Pin synchronisers, second stage read only
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hrstPipe_r <= 2'h0;
      idxPipe_r  <= 2'h0;
      idxLast_r  <= 1'b0;
    end else begin
      hrstPipe_r <= {hrstPipe_r[0], host_reset_pin};
      idxPipe_r  <= {idxPipe_r[0], indexPulse};
      idxLast_r  <= idxPipe_r[1];
    end
  end
  assign hostRst = hrstPipe_r[1];
  assign idxEdge = idxPipe_r[1] & ~idxLast_r;

  // ==========================================================================
  // Bus decode
  logic waitReq_r;    // Waitrequest flop, high while idle
  logic waitReq_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic accept;       // Edge at which the request completes
  logic wrAux;        // Accepted write to control register, low lane
  logic wrMask;       // Accepted write to mask register
  logic rdStat;       // Accepted read of status register

  assign accept = (avs_read | avs_write) & ~waitReq_r;
  assign wrAux  = accept & avs_write & avs_byteenable[0]
                  & (avs_address == `ACSR_ADDR_AUX);
  assign wrMask = accept & avs_write & avs_byteenable[0]
                  & (avs_address == `ACSR_ADDR_IRQ_MASK);
  assign rdStat = accept & avs_read & (avs_address == `ACSR_ADDR_IRQ_STAT);

  // ==========================================================================
  // Control bits
  acsr_ctrl_t ctrl_r;    // Written control fields
  acsr_ctrl_t ctrl_nxt;
  logic syncTo_r;        // Sync timeout error
  logic syncTo_nxt;
  logic hprst_r;         // Host program reset status
  logic hprst_nxt;

  // Next values of control and sticky bits
  always_comb begin
    ctrl_nxt   = ctrl_r;
    syncTo_nxt = syncTo_r;
    hprst_nxt  = hprst_r;
    // Software writes; reserved bit 1 is never stored
    if (wrAux) begin
      ctrl_nxt.autoInc = avs_writedata[`ACSR_BIT_AUTOINC];
      ctrl_nxt.clrDma  = avs_writedata[`ACSR_BIT_CLRDMA];
      ctrl_nxt.detEn   = avs_writedata[`ACSR_BIT_DETEN];
      if (avs_writedata[`ACSR_BIT_BYTERDY]) begin
        hprst_nxt = 1'b0;
      end
    end
    // Host program reset holds status high, set wins
    if (hostProgReset) begin
      hprst_nxt = 1'b1;
    end
    // Host reset pin or host program reset drops the DMA-clear strobe
    if (hostRst | hostProgReset) begin
      ctrl_nxt.clrDma = 1'b0;
    end
    // Formatter reset clears formatter-side fields
    if (formatterReset) begin
      ctrl_nxt.detEn = 1'b0;
      syncTo_nxt     = 1'b0;
    end
    // Timeout expiry sets error, winning over clear
    if (syncTimeoutPulse) begin
      syncTo_nxt = 1'b1;
    end
  end

  // Control register flops, cleared by local reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_r   <= '0;
      syncTo_r <= 1'b0;
      hprst_r  <= 1'b0;
    end else begin
      ctrl_r   <= ctrl_nxt;
      syncTo_r <= syncTo_nxt;
      hprst_r  <= hprst_nxt;
    end
  end

  // ==========================================================================
  // Two-index detector
  acsr_det_t det_r;      // Detector state
  acsr_det_t det_nxt;
  logic idxSeen_r;       // One index edge seen while armed
  logic idxSeen_nxt;
  logic armReq;          // Control store arming word

  // Arming word: gate and transfer off, count bit 5 on
  assign armReq = ctrl_r.detEn & wcsWord.step & ~wcsWord.readGate
                  & ~wcsWord.dataXfer & wcsWord.countBit5;

  // Detector next state
  always_comb begin
    det_nxt     = det_r;
    idxSeen_nxt = idxSeen_r;
    case (det_r)
      DET_IDLE: begin
        if (armReq) begin
          det_nxt     = DET_ARMED;
          idxSeen_nxt = 1'b0;
        end
      end
      DET_ARMED: begin
        if (fmtBufXfer) begin
          det_nxt     = DET_IDLE;
          idxSeen_nxt = 1'b0;
        end else if (armReq) begin
          idxSeen_nxt = 1'b0;  // Rearm restarts count
        end else if (idxEdge & idxSeen_r) begin
          det_nxt     = DET_DETECTED;
          idxSeen_nxt = 1'b0;
        end else if (idxEdge) begin
          idxSeen_nxt = 1'b1;
        end
      end
      DET_DETECTED: begin
        // Status stands until rearm or disable
        if (armReq) begin
          det_nxt = DET_ARMED;
        end
      end
      default: begin
        det_nxt     = DET_IDLE;
        idxSeen_nxt = 1'b0;
      end
    endcase
    // Disable or formatter reset ends everything
    if (~ctrl_nxt.detEn) begin
      det_nxt     = DET_IDLE;
      idxSeen_nxt = 1'b0;
    end
  end

  // Detector flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      det_r     <= DET_IDLE;
      idxSeen_r <= 1'b0;
    end else begin
      det_r     <= det_nxt;
      idxSeen_r <= idxSeen_nxt;
    end
  end

  // ==========================================================================
  // Register image and interrupt events
  logic [7:0] auxImage;   // Read value of control register
  logic [3:0] evStat_r;   // Sticky event status
  logic [3:0] evStat_nxt;
  logic [3:0] evMask_r;   // Event mask
  logic [3:0] evMask_nxt;
  logic [3:0] events;     // One-cycle event set
  logic       byteRdyLast_r;

  // Compose the read image of the control register
  always_comb begin
    auxImage                   = `ACSR_AUX_RESET;
    auxImage[`ACSR_BIT_AUTOINC] = ctrl_r.autoInc;
    auxImage[`ACSR_BIT_RSVD]    = 1'b0;
    auxImage[`ACSR_BIT_SYNCTO]  = syncTo_r;
    auxImage[`ACSR_BIT_TWOIDX]  = (det_r == DET_DETECTED);
    auxImage[`ACSR_BIT_CLRDMA]  = ctrl_r.clrDma;
    auxImage[`ACSR_BIT_HPRST]   = hprst_r;
    auxImage[`ACSR_BIT_DETEN]   = ctrl_r.detEn;
    auxImage[`ACSR_BIT_BYTERDY] = byteReady;
  end

  // Rising edges of status conditions
  always_comb begin
    events                   = `ACSR_EV_RESET;
    events[`ACSR_EV_SYNCTO]  = syncTo_nxt & ~syncTo_r;
    events[`ACSR_EV_TWOIDX]  = (det_nxt == DET_DETECTED) & (det_r != DET_DETECTED);
    events[`ACSR_EV_HPRST]   = hprst_nxt & ~hprst_r;
    events[`ACSR_EV_BYTERDY] = byteReady & ~byteRdyLast_r;
  end

  // Status clears on read, a new event wins
  always_comb begin
    evStat_nxt = rdStat ? events : (evStat_r | events);
    evMask_nxt = wrMask ? avs_writedata[3:0] : evMask_r;
  end

  // Interrupt flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      evStat_r      <= `ACSR_EV_RESET;
      evMask_r      <= `ACSR_EV_RESET;
      byteRdyLast_r <= 1'b1;  // Idle level high, no false rise after reset
    end else begin
      evStat_r      <= evStat_nxt;
      evMask_r      <= evMask_nxt;
      byteRdyLast_r <= byteReady;
    end
  end

  // ==========================================================================
  // Bus answer: one wait cycle, then acknowledge
  always_comb begin
    waitReq_nxt = 1'b1;
    rdata_nxt   = rdata_r;
    if ((avs_read | avs_write) & waitReq_r) begin
      waitReq_nxt = 1'b0;  // Answer on the next edge
      rdata_nxt   = `ACSR_RDATA_RESET;
      case (avs_address)
        `ACSR_ADDR_AUX:      rdata_nxt[7:0] = auxImage;
        `ACSR_ADDR_IRQ_STAT: rdata_nxt[3:0] = evStat_r | events;
        `ACSR_ADDR_IRQ_MASK: rdata_nxt[3:0] = evMask_r;
        default:             rdata_nxt      = `ACSR_RDATA_RESET;  // Unmapped reads zero
      endcase
    end
  end

  // Bus flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      waitReq_r <= 1'b1;
      rdata_r   <= `ACSR_RDATA_RESET;
    end else begin
      waitReq_r <= waitReq_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // ==========================================================================
  // Registered outputs
  logic ptrIncr_r;
  logic irq_r;
  logic armed_r;    // Detector armed
  logic stopped_r;  // Two-index status, halts formatter

  // Pointer step and interrupt level
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ptrIncr_r <= 1'b0;
      irq_r     <= 1'b0;
      armed_r   <= 1'b0;
      stopped_r <= 1'b0;
    end else begin
      ptrIncr_r <= bufPortAccess & ctrl_r.autoInc;
      irq_r     <= |(evStat_nxt & evMask_nxt);
      armed_r   <= (det_nxt == DET_ARMED);
      stopped_r <= (det_nxt == DET_DETECTED);
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = waitReq_r;
  assign bufPtrIncr      = ptrIncr_r;
  assign clearDmaEnable  = ctrl_r.clrDma;
  assign detArmed        = armed_r;
  assign fmtStopped      = stopped_r;
  assign irq             = irq_r;

endmodule

// ==== verification/acsr_checker.sv ====
// Concurrent checks on the ports of the auxiliary control register block
`timescale 1ns/1ns
module acsr_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic              clock,
  input wire logic              resetn,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic              host_reset_pin,
  input wire logic              hostProgReset,
  input wire logic              formatterReset,
  input wire logic              syncTimeoutPulse,
  input wire logic              byteReady,
  input wire logic              indexPulse,
  input wire logic              fmtBufXfer,
  input wire logic              bufPortAccess,
  input wire acsr_pkg::acsr_wcs_t wcsWord,
  input wire logic              bufPtrIncr,
  input wire logic              clearDmaEnable,
  input wire logic              detArmed,
  input wire logic              fmtStopped,
  input wire logic              irq
);
  // ==========================================================================
  // One domain: shared clock and reset
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // ==========================================================================
  // Bus answers and event responses
  AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_INCR_CAUSE: assert property (bufPtrIncr |-> $past(bufPortAccess))
    else $error("pointer increment without a data port access");
  AST_ARM_CAUSE: assert property ($rose(detArmed) |->
    $past(wcsWord.step && !wcsWord.readGate && !wcsWord.dataXfer && wcsWord.countBit5))
    else $error("detector armed without an arming word");
  AST_XFER_DISARM: assert property (detArmed && fmtBufXfer && !wcsWord.step |=> !detArmed)
    else $error("transfer did not disarm detector");
  AST_STOP_CAUSE: assert property ($rose(fmtStopped) |-> $past(detArmed))
    else $error("stopped raised while detector not armed");
  AST_STOP_DISARM: assert property (fmtStopped |-> !detArmed)
    else $error("detector armed while formatter stopped");
  AST_FMT_RESET: assert property (formatterReset |=> !fmtStopped && !detArmed)
    else $error("formatter reset left detector state");
  AST_CLRDMA_HPR: assert property (hostProgReset && !avs_write |=> !clearDmaEnable)
    else $error("clear DMA strobe kept during host program reset");
endmodule

bind acsr_top acsr_checker #(.ADDR_W(ADDR_W)) i_chk (
  .clock, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_readdata, .avs_waitrequest, .host_reset_pin, .hostProgReset, .formatterReset,
  .syncTimeoutPulse, .byteReady, .indexPulse, .fmtBufXfer, .bufPortAccess, .wcsWord,
  .bufPtrIncr, .clearDmaEnable, .detArmed, .fmtStopped, .irq
);

// ==== verification/testbench.sv ====
// Self-checking bench for the auxiliary control register block
`timescale 1ns/1ns
module testbench;
  import acsr_pkg::*;
  // ==========================================================================
  // Stimulus and observed signals
  logic        clock = 0, resetn = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [7:0]  avs_address = '0, rnd = 8'h42;
  logic [31:0] avs_writedata = '0, avs_readdata;
  logic [3:0]  avs_byteenable = '0;
  logic        host_reset_pin = 0, hostProgReset = 0, formatterReset = 0;
  logic        syncTimeoutPulse = 0, byteReady = 0, indexPulse = 0, fmtBufXfer = 0;
  logic        bufPortAccess = 0, bufPtrIncr, clearDmaEnable, detArmed, fmtStopped, irq;
  acsr_wcs_t   wcsWord = '0;
  logic [32:0] expQ[$];  // Read flag and expected read data
  logic [32:0] note;     // Oldest note taken by the watcher
  int          errorCnt = 0, nCompared = 0;

  always #25 clock = ~clock;

  acsr_top i_dut (
    .clock, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .host_reset_pin, .hostProgReset, .formatterReset,
    .syncTimeoutPulse, .byteReady, .indexPulse, .fmtBufXfer, .bufPortAccess, .wcsWord,
    .bufPtrIncr, .clearDmaEnable, .detArmed, .fmtStopped, .irq
  );

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      errorCnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bus answer watcher takes the oldest note
  always @(posedge clock) begin
    if (resetn && avs_waitrequest === 1'b0 && expQ.size() > 0) begin
      note = expQ.pop_front();
      if (note[32]) chk(avs_readdata, note[31:0]);
    end
  end

  // One Avalon transfer, entered just after a rising edge
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] wd,
                     input logic [31:0] ex);
    rnd = lfsr(rnd);
    expQ.push_back({rd, ex});
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= wd;
    avs_byteenable <= {rnd[2:0], 1'b1};
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clock);
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    bus(1'b1, a, 32'h0, ex);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b0, a, {rnd, rnd, rnd, d}, 32'h0);
  endtask

  // Output s after n edges: 0 irq, 1 incr, 2 clrDma, 3 armed, 4 stopped
  task automatic obs(input int n, input int s, input logic e);
    logic [4:0] v;
    tick(n);
    @(negedge clock);
    v = {fmtStopped, detArmed, clearDmaEnable, bufPtrIncr, irq};
    chk(32'(v[s]), 32'(e));
    @(posedge clock);
  endtask

  task automatic arm;
    wcsWord <= 4'b1001;
    tick(1);
    wcsWord <= '0;
  endtask

  task automatic idx(input int k);
    repeat (k) begin
      indexPulse <= 1'b1;
      tick(3);
      indexPulse <= 1'b0;
      tick(3);
    end
  endtask

  task automatic report_and_stop;
    $display("errors=%0d compared=%0d", errorCnt, nCompared);
    if (errorCnt == 0 && nCompared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  initial begin
    tick(4);
    resetn <= 1'b1;
    tick(5);
    rd(8'h48, 32'h00);
    rd(8'h4c, 32'h00);
    rd(8'h44, 32'h00);
    wr(8'h50, 8'h0f);
    rd(8'h50, 32'h0f);
    syncTimeoutPulse <= 1'b1;
    tick(1);
    syncTimeoutPulse <= 1'b0;
    obs(1, 0, 1'b1);
    rd(8'h48, 32'h04);
    rd(8'h4c, 32'h01);
    obs(1, 0, 1'b0);
    formatterReset <= 1'b1;
    tick(1);
    formatterReset <= 1'b0;
    rd(8'h48, 32'h00);
    wr(8'h48, 8'hff);
    rd(8'h48, 32'h51);
    obs(0, 2, 1'b1);
    hostProgReset <= 1'b1;
    obs(1, 2, 1'b0);
    rd(8'h48, 32'h61);
    hostProgReset <= 1'b0;
    rd(8'h48, 32'h61);
    wr(8'h48, 8'hd1);
    rd(8'h48, 32'h51);
    rd(8'h4c, 32'h04);
    host_reset_pin <= 1'b1;
    obs(4, 2, 1'b0);
    host_reset_pin <= 1'b0;
    tick(3);
    bufPortAccess <= 1'b1;
    tick(1);
    bufPortAccess <= 1'b0;
    obs(0, 1, 1'b1);
    wr(8'h48, 8'h40);
    bufPortAccess <= 1'b1;
    tick(1);
    bufPortAccess <= 1'b0;
    obs(0, 1, 1'b0);
    for (int i = 0; i < 8; i++) begin
      wcsWord <= {1'b1, i[2:0]};
      tick(1);
      wcsWord <= '0;
      obs(0, 3, i == 1);
      fmtBufXfer <= 1'b1;
      tick(1);
      fmtBufXfer <= 1'b0;
      obs(0, 3, 1'b0);
    end
    wr(8'h48, 8'h00);
    arm();
    obs(0, 3, 1'b0);
    wr(8'h48, 8'h40);
    arm();
    idx(2);
    obs(2, 4, 1'b1);
    obs(0, 3, 1'b0);
    rd(8'h48, 32'h48);
    rd(8'h4c, 32'h02);
    arm();
    obs(0, 4, 1'b0);
    idx(1);
    fmtBufXfer <= 1'b1;
    tick(1);
    fmtBufXfer <= 1'b0;
    idx(1);
    obs(2, 4, 1'b0);
    arm();
    idx(2);
    obs(2, 4, 1'b1);
    wr(8'h48, 8'h00);
    obs(0, 4, 1'b0);
    wr(8'h48, 8'h40);
    formatterReset <= 1'b1;
    tick(1);
    formatterReset <= 1'b0;
    rd(8'h48, 32'h00);
    rd(8'h4c, 32'h02);
    wr(8'h50, 8'h00);
    byteReady <= 1'b1;
    obs(2, 0, 1'b0);
    rd(8'h48, 32'h80);
    rd(8'h4c, 32'h08);
    wr(8'h48, 8'h51);
    wr(8'h50, 8'h0f);
    resetn <= 1'b0;
    tick(2);
    resetn <= 1'b1;
    tick(5);
    rd(8'h48, 32'h80);
    rd(8'h50, 32'h00);
    rd(8'h4c, 32'h00);
    report_and_stop();
  end

  // Hang guard, well beyond the scenario length
  initial begin
    tick(3000);
    errorCnt++;
    report_and_stop();
  end
endmodule
